// [include/opv_pkg.sv]
`default_nettype none
package opv_pkg;
    localparam int PROM_STEPS = 1002;
    localparam int WORD_W = 10;
    localparam int LOC_W = 10;
    localparam int BYTE_W = 8;
    localparam logic [9:0] RESET_VECTOR = 10'h000;
    localparam logic [9:0] TEST_AREA_FIRST = 10'h3EA;
    localparam logic [1:0] LAST_PULSE = 2'h3;
    // Mode pins as {pin3, pin2, pin1, pin0}
    localparam logic [3:0] MD_CLEAR_PAT = 4'h5;
    localparam logic [3:0] MD_WRITE_PAT = 4'hE;
    localparam logic [3:0] MD_VERIFY_PAT = 4'hC;
    localparam logic [3:0] MD_INHIBIT_PAT = 4'hD;
    localparam logic [3:0] MD_INHIBIT_CARE = 4'hD;
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int RESET_HOLD_NS = 10000;
    localparam int RESET_HOLD_CYCLES =
        (RESET_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_W = LOC_W + BYTE_W;
    // Synchronised pin vector layout
    localparam int PIN_MODE_LSB = 0;
    localparam int PIN_DATA_LSB = 4;
    localparam int PIN_CLK = 12;
    localparam int PIN_RST = 13;
    localparam int PIN_SUP = 14;
    localparam int SYNC_W = 15;
    // Register map, byte addresses
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] REG_PC = 8'h00;
    localparam logic [7:0] REG_FETCH = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    localparam logic CTRL_EN_RESET = 1'h1;
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_MODE_LSB = 1;
    localparam int ST_LOC_LSB = 8;
    localparam int ST_PULSE_LSB = 20;
    localparam int ST_FIFO_BIT = 24;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MODE_NONE,
        MODE_CLEAR,
        MODE_WRITE,
        MODE_VERIFY,
        MODE_INHIBIT
    } opv_mode_t;

    function automatic opv_mode_t decode_mode(input logic [3:0] md);
        if (md == MD_CLEAR_PAT) return MODE_CLEAR;
        if (md == MD_WRITE_PAT) return MODE_WRITE;
        if (md == MD_VERIFY_PAT) return MODE_VERIFY;
        if ((md & MD_INHIBIT_CARE) == MD_INHIBIT_PAT) return MODE_INHIBIT;
        return MODE_NONE;
    endfunction

    // Anything landing in the test area restarts at the reset vector
    function automatic logic [9:0] redirect(input logic [9:0] a);
        return (a >= TEST_AREA_FIRST) ? RESET_VECTOR : a;
    endfunction
endpackage
`default_nettype wire

// [include/opv_fifo_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface opv_fifo_if #(parameter int W = 18);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport fifo (input in_valid, input in_data, input out_ready,
                  output in_ready, output out_valid, output out_data);
    modport user (output in_valid, output in_data, output out_ready,
                  input in_ready, input out_valid, input out_data);
endinterface
`default_nettype wire

// [rtl/opv_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module opv_fifo #(
    parameter int W = 18,
    parameter int DEPTH = 32
) (
    input wire logic clock,
    input wire logic rst,
    opv_fifo_if.fifo port
);
    localparam int PW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << PW) != DEPTH)
        begin : g_bad_depth
            $error("FIFO depth must be a power of two, at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] count;
    } opv_fifo_state_t;

    opv_fifo_state_t s_q;
    opv_fifo_state_t s_d;
    logic [W-1:0] store_q [DEPTH];
    logic push;
    logic pop;

    assign port.in_ready = s_q.count != (PW+1)'(DEPTH);
    assign port.out_valid = s_q.count != '0;
    assign port.out_data = store_q[s_q.rd_ptr];
    assign push = port.in_valid && port.in_ready;
    assign pop = port.out_valid && port.out_ready;

    always_comb
    begin
        s_d = s_q;
        if (push)
            s_d.wr_ptr = s_q.wr_ptr + 1'b1;
        if (pop)
            s_d.rd_ptr = s_q.rd_ptr + 1'b1;
        s_d.count = s_q.count + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
        if (push)
            store_q[s_q.wr_ptr] <= port.in_data;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    fifo_no_overflow_a: assert property (s_q.count <= (PW+1)'(DEPTH))
        else $error("fifo count beyond depth");
    fifo_count_track_a: assert property (
        push && !pop |=> s_q.count == $past(s_q.count) + 1'b1)
        else $error("fifo count missed a push");
endmodule
`default_nettype wire

// [rtl/opv_otp_port.sv]
`timescale 1ns/1ps
`default_nettype none
module opv_otp_port #(
    parameter int HOLD_CYCLES = opv_pkg::RESET_HOLD_CYCLES,
    parameter int FIFO_DEPTH = opv_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [opv_pkg::AXI_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [opv_pkg::AXI_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [3:0] prog_mode_select,
    input wire logic [7:0] prog_data_bus_sense,
    output logic [7:0] prog_data_bus_drive,
    output logic prog_data_bus_oe,
    input wire logic prog_clock_pin,
    input wire logic core_reset_pin,
    input wire logic prog_supply_pin
);
    localparam int HW = $clog2(HOLD_CYCLES + 1);
    localparam int SW = opv_pkg::SYNC_W;

    generate
        if (HOLD_CYCLES < 1)
        begin : g_bad_hold
            $error("HOLD_CYCLES must be at least one");
        end
    endgenerate

    typedef struct packed {
        logic [SW-1:0] sync1;
        logic [SW-1:0] sync2;
        logic [SW-1:0] sync3;
        logic [SW-1:0] pins;
        logic [HW-1:0] hold_cnt;
        logic prog_active;
        logic [9:0] loc;
        logic [1:0] pulse_cnt;
        opv_pkg::opv_mode_t mode_prev;
        logic push_pend;
        logic [7:0] push_data;
        logic [9:0] push_loc;
        logic ctrl_en;
        logic [9:0] pc;
        logic data_oe;
        logic awready;
        logic aw_got;
        logic [opv_pkg::AXI_ADDR_W-1:0] aw_addr;
        logic wready;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } opv_state_t;

    opv_state_t s_q;
    opv_state_t s_d;
    opv_pkg::opv_mode_t cur_mode;
    logic [SW-1:0] pin_vec;
    logic pulse_edge;
    logic supply_rise;
    logic [31:0] status;
    logic [9:0] pc_wr;
    logic mem_we;
    logic [9:0] mem_addr;
    logic [7:0] mem_byte;
    logic [9:0] prom_q [opv_pkg::PROM_STEPS];
    logic [9:0] fetch_word_q;
    logic [7:0] verify_byte_q;

    opv_fifo_if #(.W(opv_pkg::FIFO_W)) fifo_bus ();

    opv_fifo #(
        .W(opv_pkg::FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .port(fifo_bus.fifo)
    );

    assign pin_vec = {prog_supply_pin, core_reset_pin, prog_clock_pin,
                      prog_data_bus_sense, prog_mode_select};
    assign cur_mode = opv_pkg::decode_mode(
        s_q.pins[opv_pkg::PIN_MODE_LSB +: 4]);
    // Accepted rise: second and third stage agree on a new level
    assign pulse_edge = s_q.sync2[opv_pkg::PIN_CLK]
        && s_q.sync3[opv_pkg::PIN_CLK] && !s_q.pins[opv_pkg::PIN_CLK];
    assign supply_rise = s_q.sync2[opv_pkg::PIN_SUP]
        && s_q.sync3[opv_pkg::PIN_SUP] && !s_q.pins[opv_pkg::PIN_SUP];

    // Queued writes stay put while the programmer verifies
    assign fifo_bus.in_valid = s_q.push_pend;
    assign fifo_bus.in_data = {s_q.push_loc, s_q.push_data};
    assign fifo_bus.out_ready =
        !(s_q.prog_active && cur_mode == opv_pkg::MODE_VERIFY);
    assign mem_addr = fifo_bus.out_data[opv_pkg::BYTE_W +: 10];
    assign mem_byte = fifo_bus.out_data[7:0];
    assign mem_we = fifo_bus.out_valid && fifo_bus.out_ready
        && mem_addr < 10'(opv_pkg::PROM_STEPS);

    assign pc_wr = {s_q.w_strb[1] ? s_q.w_data[9:8] : s_q.pc[9:8],
                    s_q.w_strb[0] ? s_q.w_data[7:0] : s_q.pc[7:0]};

    always_comb
    begin
        s_d = s_q;
        status = '0;
        status[opv_pkg::ST_ACTIVE_BIT] = s_q.prog_active;
        status[opv_pkg::ST_MODE_LSB +: 3] = cur_mode;
        status[opv_pkg::ST_LOC_LSB +: 10] = s_q.loc;
        status[opv_pkg::ST_PULSE_LSB +: 2] = s_q.pulse_cnt;
        status[opv_pkg::ST_FIFO_BIT] = fifo_bus.out_valid;

        // Three-stage pin synchroniser
        s_d.sync1 = pin_vec;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        for (int i = 0; i < SW; i++)
        begin
            if (s_q.sync2[i] == s_q.sync3[i])
                s_d.pins[i] = s_q.sync3[i];
        end

        // Location counter
        if (s_q.prog_active)
        begin
            if (cur_mode == opv_pkg::MODE_CLEAR)
            begin
                s_d.loc = '0;
                s_d.pulse_cnt = '0;
            end
            else if (pulse_edge)
            begin
                s_d.pulse_cnt = s_q.pulse_cnt + 1'b1;
                if (s_q.pulse_cnt == opv_pkg::LAST_PULSE)
                    s_d.loc = s_q.loc + 1'b1;
            end
        end

        // Entry needs a long enough reset hold before the supply rises
        if (s_q.pins[opv_pkg::PIN_RST] && !s_q.pins[opv_pkg::PIN_SUP])
        begin
            if (s_q.hold_cnt != HW'(HOLD_CYCLES))
                s_d.hold_cnt = s_q.hold_cnt + 1'b1;
        end
        else if (!s_q.pins[opv_pkg::PIN_RST])
            s_d.hold_cnt = '0;
        if (!s_q.pins[opv_pkg::PIN_SUP])
            s_d.prog_active = 1'b0;
        if (supply_rise && s_q.ctrl_en
            && s_q.hold_cnt == HW'(HOLD_CYCLES))
        begin
            s_d.prog_active = 1'b1;
            s_d.loc = '0;
            s_d.pulse_cnt = '0;
        end

        // One capture per entry into write mode; inhibit re-arms it
        s_d.mode_prev = s_q.prog_active ? cur_mode : opv_pkg::MODE_NONE;
        if (fifo_bus.in_valid && fifo_bus.in_ready)
            s_d.push_pend = 1'b0;
        if (s_q.prog_active && cur_mode == opv_pkg::MODE_WRITE
            && s_q.mode_prev != opv_pkg::MODE_WRITE)
        begin
            s_d.push_pend = 1'b1;
            s_d.push_data = s_q.pins[opv_pkg::PIN_DATA_LSB +: 8];
            s_d.push_loc = s_q.loc;
        end
        s_d.data_oe = s_q.prog_active
            && cur_mode == opv_pkg::MODE_VERIFY;

        // Read channel
        if (s_q.rvalid && rready)
            s_d.rvalid = 1'b0;
        if (arvalid && s_q.arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = opv_pkg::RESP_OKAY;
            s_d.rdata = '0;
            case (araddr)
                opv_pkg::REG_PC:
                    s_d.rdata[9:0] = s_q.pc;
                opv_pkg::REG_FETCH:
                begin
                    s_d.rdata[9:0] = fetch_word_q;
                    s_d.pc = opv_pkg::redirect(s_q.pc + 1'b1);
                end
                opv_pkg::REG_STATUS:
                    s_d.rdata = status;
                opv_pkg::REG_CTRL:
                    s_d.rdata[0] = s_q.ctrl_en;
                default:
                    s_d.rresp = opv_pkg::RESP_SLVERR;
            endcase
        end
        s_d.arready = !s_d.rvalid;

        // Write channel: address and data in either order
        if (awvalid && s_q.awready)
        begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && s_q.wready)
        begin
            s_d.w_got = 1'b1;
            s_d.w_data = wdata;
            s_d.w_strb = wstrb;
        end
        if (s_q.bvalid && bready)
            s_d.bvalid = 1'b0;
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = opv_pkg::RESP_OKAY;
            case (s_q.aw_addr)
                // A PC write beats a fetch advance in the same cycle
                opv_pkg::REG_PC:
                    s_d.pc = opv_pkg::redirect(pc_wr);
                opv_pkg::REG_CTRL:
                begin
                    if (s_q.w_strb[0])
                        s_d.ctrl_en = s_q.w_data[0];
                end
                opv_pkg::REG_FETCH, opv_pkg::REG_STATUS:
                    s_d.bresp = opv_pkg::RESP_OKAY;
                default:
                    s_d.bresp = opv_pkg::RESP_SLVERR;
            endcase
        end
        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready = !s_d.w_got && !s_d.bvalid;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.ctrl_en <= opv_pkg::CTRL_EN_RESET;
            s_q.pc <= opv_pkg::RESET_VECTOR;
            s_q.awready <= 1'b1;
            s_q.wready <= 1'b1;
            s_q.arready <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // Array reset models a blank part; programming only sets bits
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            for (int i = 0; i < opv_pkg::PROM_STEPS; i++)
                prom_q[i] <= '0;
            fetch_word_q <= '0;
            verify_byte_q <= '0;
        end
        else
        begin
            if (mem_we)
                prom_q[mem_addr] <= prom_q[mem_addr] | {2'h0, mem_byte};
            fetch_word_q <= prom_q[s_q.pc];
            // Test area reads back as zero
            if (s_q.loc < 10'(opv_pkg::PROM_STEPS))
                verify_byte_q <= prom_q[s_q.loc][7:0];
            else
                verify_byte_q <= '0;
        end
    end

    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rdata = s_q.rdata;
    assign rresp = s_q.rresp;
    assign prog_data_bus_drive = verify_byte_q;
    assign prog_data_bus_oe = s_q.data_oe;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_fourth_pulse;
        s_q.prog_active && pulse_edge && cur_mode != opv_pkg::MODE_CLEAR
            && s_q.pulse_cnt == opv_pkg::LAST_PULSE;
    endsequence

    sequence s_early_pulse;
        s_q.prog_active && pulse_edge && cur_mode != opv_pkg::MODE_CLEAR
            && s_q.pulse_cnt != opv_pkg::LAST_PULSE && !supply_rise;
    endsequence

    sequence s_write_entry;
        s_q.prog_active && cur_mode == opv_pkg::MODE_WRITE
            && s_q.mode_prev != opv_pkg::MODE_WRITE;
    endsequence

    loc_step_four_a: assert property (
        s_fourth_pulse ##0 !supply_rise |=> s_q.loc == $past(s_q.loc) + 1'b1)
        else $error("location did not step on fourth pulse");
    loc_hold_early_a: assert property (
        s_early_pulse |=> s_q.loc == $past(s_q.loc))
        else $error("location stepped before fourth pulse");
    clear_mode_zero_a: assert property (
        s_q.prog_active && cur_mode == opv_pkg::MODE_CLEAR
            |=> s_q.loc == '0 && s_q.pulse_cnt == '0)
        else $error("clear mode left counter nonzero");
    entry_after_hold_a: assert property (
        $rose(s_q.prog_active) |-> $past(s_q.hold_cnt) == HW'(HOLD_CYCLES)
            && $past(s_q.ctrl_en))
        else $error("port entered without reset hold");
    pc_out_test_a: assert property (
        s_q.pc < 10'(opv_pkg::PROM_STEPS))
        else $error("program counter inside test area");
    bus_verify_only_a: assert property (
        prog_data_bus_oe |-> $past(s_q.prog_active
            && cur_mode == opv_pkg::MODE_VERIFY))
        else $error("data bus driven outside verify");
    write_capture_a: assert property (
        s_write_entry |=> s_q.push_pend && s_q.push_data
            == $past(s_q.pins[opv_pkg::PIN_DATA_LSB +: 8]))
        else $error("write byte not captured");
    array_range_a: assert property (
        mem_we |-> mem_addr < 10'(opv_pkg::PROM_STEPS))
        else $error("array write outside program area");
    write_resp_a: assert property (
        $rose(s_q.bvalid) |-> $past(s_q.aw_got && s_q.w_got))
        else $error("write response without address and data");
endmodule
`default_nettype wire

// [verification/opv_prog_model.sv]
`timescale 1ns/1ps
`default_nettype none
module opv_prog_model #(
    parameter int HOLD = 4,
    parameter int WRITE_CYCLES = 1000
) (
    input wire logic clock, // Stands in for the resonator
    input wire logic [7:0] bus,
    output logic [3:0] mode,
    output logic [7:0] dout,
    output logic den,
    output logic clk_pin,
    output logic reset_pin,
    output logic supply_pin
);
    initial
    begin
        mode = opv_pkg::MD_CLEAR_PAT;
        dout = 8'h00;
        den = 1'b0;
        clk_pin = 1'b0;
        reset_pin = 1'b1;
        supply_pin = 1'b0;
    end

    task automatic step(input logic [3:0] m, input logic [7:0] d,
                        input logic en, input int n);
        @(posedge clock);
        mode <= m;
        dout <= d;
        den <= en;
        repeat (n) @(posedge clock);
    endtask

    task automatic power_up();
        repeat (HOLD + 10) @(posedge clock);
        step(opv_pkg::MD_CLEAR_PAT, 8'h00, 1'b0, 8);
        supply_pin <= 1'b1;
        step(opv_pkg::MD_INHIBIT_PAT, 8'h00, 1'b0, 8);
    endtask

    // Moves the core reset and supply levels, then lets them settle
    task automatic set_pins(input logic r, input logic s);
        @(posedge clock);
        reset_pin <= r;
        supply_pin <= s;
        repeat (8) @(posedge clock);
    endtask

    // Callers keep below the test area
    task automatic program_loc(input logic [7:0] d);
        int x;
        logic ok;
        x = 0;
        do
        begin
            step(opv_pkg::MD_INHIBIT_PAT, d, 1'b1, 8);
            step(opv_pkg::MD_WRITE_PAT, d, 1'b1, WRITE_CYCLES);
            step(opv_pkg::MD_INHIBIT_PAT, d, 1'b1, 8);
            step(opv_pkg::MD_VERIFY_PAT, 8'h00, 1'b0, 8);
            // Judge the readback while the device still drives it
            ok = (bus === d);
            x++;
            // Release the bus before driving again, avoids contention
            step(opv_pkg::MD_INHIBIT_PAT, 8'h00, 1'b0, 8);
        end
        while (!ok && x < 4);
        step(opv_pkg::MD_INHIBIT_PAT, d, 1'b1, 8);
        step(opv_pkg::MD_WRITE_PAT, d, 1'b1, x * WRITE_CYCLES);
        step(opv_pkg::MD_INHIBIT_PAT, d, 1'b1, 8);
    endtask

    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge clock);
            clk_pin <= 1'b1;
            repeat (5) @(posedge clock);
            clk_pin <= 1'b0;
            repeat (5) @(posedge clock);
        end
    endtask

    task automatic finish();
        step(opv_pkg::MD_CLEAR_PAT, 8'h00, 1'b0, 8);
        supply_pin <= 1'b0;
        repeat (8) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// [verification/opv_otp_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module opv_otp_port_tb;
    logic clock, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, oe, pclk, rpin, spin, mden;
    logic [7:0] awaddr, araddr, sense, drive, mdout;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, md;
    logic [1:0] bresp, rresp;
    int n_fail = 0;
    int checks_done = 0;

    // Undriven data pins sit on pull-downs
    assign sense = oe ? drive : (mden ? mdout : 8'h00);

    opv_otp_port #(.HOLD_CYCLES(4)) dut (
        .clock(clock), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .prog_mode_select(md), .prog_data_bus_sense(sense),
        .prog_data_bus_drive(drive), .prog_data_bus_oe(oe),
        .prog_clock_pin(pclk), .core_reset_pin(rpin),
        .prog_supply_pin(spin));

    opv_prog_model model (
        .clock(clock), .bus(sense), .mode(md), .dout(mdout), .den(mden),
        .clk_pin(pclk), .reset_pin(rpin), .supply_pin(spin));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d failures=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge clock);
            if (awvalid && awready === 1'b1)
                awvalid <= 1'b0;
            if (wvalid && wready === 1'b1)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge clock);
            if (arvalid && arready === 1'b1)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        rd(opv_pkg::REG_CTRL, d, r);
        check(d, 32'h1);
        rd(opv_pkg::REG_STATUS, d, r);
        check(32'(d[0]), 32'h0);
        check(32'(oe), 32'h0);
        rd(8'h10, d, r);
        check(32'(r), 32'(opv_pkg::RESP_SLVERR));
        check(d, 32'h0);
        wr(8'h10, 32'h1, 4'hF, r);
        check(32'(r), 32'(opv_pkg::RESP_SLVERR));
    endtask

    task automatic t_refuse();
        logic [31:0] d;
        logic [1:0] r;
        // Supply rise without a reset hold must not enter
        model.set_pins(1'b0, 1'b0);
        model.set_pins(1'b0, 1'b1);
        rd(opv_pkg::REG_STATUS, d, r);
        check(32'(d[0]), 32'h0);
        model.set_pins(1'b1, 1'b0);
        wr(opv_pkg::REG_CTRL, 32'h0, 4'hF, r);
        rd(opv_pkg::REG_CTRL, d, r);
        check(d, 32'h0);
        // Hold met but entry disabled by software
        model.set_pins(1'b1, 1'b1);
        rd(opv_pkg::REG_STATUS, d, r);
        check(32'(d[0]), 32'h0);
        model.set_pins(1'b1, 1'b0);
        wr(opv_pkg::REG_CTRL, 32'h1, 4'hF, r);
    endtask

    task automatic t_entry();
        logic [31:0] d;
        logic [1:0] r;
        model.power_up();
        rd(opv_pkg::REG_STATUS, d, r);
        check(32'(d[0]), 32'h1);
        check(32'(d[17:8]), 32'h0);
    endtask

    task automatic t_modes();
        logic [31:0] d;
        logic [1:0] r;
        logic [3:0] pat [6] = '{4'h5, 4'hE, 4'hC, 4'hD, 4'hF, 4'h0};
        logic [2:0] exp [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h0};
        foreach (pat[i])
        begin
            model.step(pat[i], 8'h00, 1'b0, 8);
            rd(opv_pkg::REG_STATUS, d, r);
            check(32'(d[3:1]), 32'(exp[i]));
            check(32'(oe), 32'(exp[i] == 3'h3));
        end
    endtask

    task automatic t_program();
        logic [31:0] d;
        logic [1:0] r;
        model.step(opv_pkg::MD_CLEAR_PAT, 8'h00, 1'b0, 8);
        model.program_loc(8'hA5);
        model.step(opv_pkg::MD_VERIFY_PAT, 8'h00, 1'b0, 8);
        check(32'(oe), 32'h1);
        check(32'(drive), 32'hA5);
        model.step(opv_pkg::MD_INHIBIT_PAT, 8'h00, 1'b0, 8);
        check(32'(oe), 32'h0);
        model.pulses(3);
        rd(opv_pkg::REG_STATUS, d, r);
        check(32'(d[17:8]), 32'h0);
        model.pulses(1);
        rd(opv_pkg::REG_STATUS, d, r);
        check(32'(d[17:8]), 32'h1);
        model.program_loc(8'h3C);
        model.step(opv_pkg::MD_CLEAR_PAT, 8'h00, 1'b0, 8);
        model.step(opv_pkg::MD_VERIFY_PAT, 8'h00, 1'b0, 8);
        check(32'(drive), 32'hA5);
        model.pulses(4);
        check(32'(drive), 32'h3C);
        model.step(opv_pkg::MD_INHIBIT_PAT, 8'h00, 1'b0, 8);
    endtask

    task automatic t_fetch();
        logic [31:0] d;
        logic [1:0] r;
        wr(opv_pkg::REG_PC, 32'h3EA, 4'hF, r);
        rd(opv_pkg::REG_PC, d, r);
        check(d, 32'h0);
        // Low lane only: upper PC bits are kept
        wr(opv_pkg::REG_PC, 32'h3E9, 4'hF, r);
        wr(opv_pkg::REG_PC, 32'h0C5, 4'h1, r);
        rd(opv_pkg::REG_PC, d, r);
        check(d, 32'h3C5);
        wr(opv_pkg::REG_PC, 32'h0F0, 4'h1, r);
        rd(opv_pkg::REG_PC, d, r);
        check(d, 32'h0);
        wr(opv_pkg::REG_PC, 32'h3E9, 4'hF, r);
        repeat (2) @(posedge clock);
        rd(opv_pkg::REG_FETCH, d, r);
        check(d, 32'h0);
        rd(opv_pkg::REG_FETCH, d, r);
        check(d, 32'h0A5);
        rd(opv_pkg::REG_FETCH, d, r);
        check(d, 32'h03C);
    endtask

    initial
    begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_refuse();
        t_entry();
        t_modes();
        t_program();
        t_fetch();
        model.finish();
        print_verdict();
    end

    // Whole run needs about 4500 cycles
    initial
    begin
        #(50000 * 100);
        n_fail++;
        print_verdict();
    end
endmodule
`default_nettype wire
